// *** fcf_flash_front_end.sv ***
// Flash command front end: APB registers, write-once divider, two-stage command queue.
//
// Chosen here: register access over APB.
`timescale 1ns/1ns
module fcf_flash_front_end #(
  parameter int          ADDR_W           = 8,
  parameter int          EXEC_TICKS       = 4,
  parameter int          ROW_LSB          = 6,
  parameter logic [6:0]  CMD_WORD_PROGRAM = 7'h20
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              oscClk,
  input  wire logic [7:0]        cfgSecurityByte,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   bufferEmptyIrq,
  output logic                   commandCompleteIrq,
  output logic                   flashTimingTick,
  output logic                   execBusy,
  output logic [6:0]             execCommand,
  output logic [15:0]            execAddress,
  output logic [15:0]            execData,
  output logic                   highVoltageOn
);
  typedef enum logic {FCF_ACT_IDLE, FCF_ACT_RUN} fcf_act_t;

  logic        osc1_q, osc2_q, osc3_q;
  logic        oscRise;
  logic        loaded_q, loaded_d;
  logic        prescale_q, prescale_d;
  logic [5:0]  divField_q, divField_d;
  logic [7:0]  security_q;
  logic        bEmptyIe_q, bEmptyIe_d;
  logic        cDoneIe_q, cDoneIe_d;
  logic        access_error_flag_q, access_error_flag_d;
  logic [6:0]  bufCmd_q, bufCmd_d;
  logic [15:0] bufAddr_q, bufAddr_d;
  logic [15:0] bufData_q, bufData_d;
  logic        cmdWritten_q, cmdWritten_d;
  logic        bufFull_q, bufFull_d;
  fcf_act_t    act_q, act_d;
  logic [6:0]  actCmd_q, actCmd_d;
  logic [15:0] actAddr_q, actAddr_d;
  logic [15:0] actData_q, actData_d;
  logic [7:0]  tickCnt_q, tickCnt_d;
  logic        hv_q, hv_d;
  logic [31:0] rdata_q, rdata_d;
  logic        slvErr_q, slvErr_d;
  logic        setup, wrAccess, mapped, launch, done, keepHv, moveIn;
  logic [3:0]  idx;
  logic        bufferEmpty, commandComplete;

  // Oscillator is asynchronous to the bus clock; only the second stage onward is read.
  always_ff @(posedge clk) begin
    if (rst) begin
      osc1_q <= 1'b0;
      osc2_q <= 1'b0;
      osc3_q <= 1'b0;
    end else begin
      osc1_q <= oscClk;
      osc2_q <= osc1_q;
      osc3_q <= osc2_q;
    end
  end
  assign oscRise = osc2_q && !osc3_q;

  fcf_timing_div u_div (
    .clk             (clk),
    .rst             (rst),
    .oscRise         (oscRise),
    .enable          (loaded_q),
    .prescaleByEight (prescale_q),
    .divideField     (divField_q),
    .flashTimingTick (flashTimingTick)
  );

  assign idx      = paddr[5:2];
  assign mapped   = (paddr >> 6) == '0;
  assign setup    = psel && !penable;
  assign wrAccess = psel && penable && pwrite && mapped;
  assign launch   = wrAccess && idx == fcf_pkg::IDX_STATUS
                    && pwdata[fcf_pkg::STAT_BEMPTY_BIT] && !bufFull_q;
  assign done     = act_q == FCF_ACT_RUN && flashTimingTick
                    && tickCnt_q == 8'(EXEC_TICKS - 1);
  assign keepHv   = bufFull_q && actCmd_q == CMD_WORD_PROGRAM && bufCmd_q == CMD_WORD_PROGRAM
                    && actAddr_q[15:ROW_LSB] == bufAddr_q[15:ROW_LSB];
  assign moveIn   = bufFull_q && (act_q == FCF_ACT_IDLE || (done && keepHv));
  assign bufferEmpty     = !bufFull_q;
  assign commandComplete = !bufFull_q && act_q == FCF_ACT_IDLE;

  // Register writes and the command queue.
  always_comb begin
    loaded_d     = loaded_q;
    prescale_d   = prescale_q;
    divField_d   = divField_q;
    bEmptyIe_d   = bEmptyIe_q;
    cDoneIe_d    = cDoneIe_q;
    access_error_flag_d     = access_error_flag_q;
    bufCmd_d     = bufCmd_q;
    bufAddr_d    = bufAddr_q;
    bufData_d    = bufData_q;
    cmdWritten_d = cmdWritten_q;
    bufFull_d    = bufFull_q;
    if (wrAccess) begin
      case (idx)
        fcf_pkg::IDX_DIVIDER: begin
          if (!loaded_q) begin
            prescale_d = pwdata[fcf_pkg::DIV_PRESCALE_BIT];
            divField_d = pwdata[fcf_pkg::DIV_FIELD_W-1:0];
            loaded_d   = 1'b1;
          end
        end
        fcf_pkg::IDX_CONFIG: begin
          bEmptyIe_d = pwdata[fcf_pkg::CFG_BEMPTY_IE_BIT];
          cDoneIe_d  = pwdata[fcf_pkg::CFG_CDONE_IE_BIT];
        end
        fcf_pkg::IDX_STATUS: begin
          if (pwdata[fcf_pkg::STAT_ACCESS_ERROR_FLAG_BIT]) begin
            access_error_flag_d = 1'b0;
          end
        end
        fcf_pkg::IDX_COMMAND: begin
          if (!bufFull_q) begin
            bufCmd_d     = pwdata[fcf_pkg::CMD_W-1:0];
            cmdWritten_d = 1'b1;
          end
        end
        fcf_pkg::IDX_ADDR_HI: begin
          if (!bufFull_q) begin
            bufAddr_d[15:8] = pwdata[7:0];
          end
        end
        fcf_pkg::IDX_ADDR_LO: begin
          if (!bufFull_q) begin
            bufAddr_d[7:0] = pwdata[7:0];
          end
        end
        fcf_pkg::IDX_DATA_HI: begin
          if (!bufFull_q) begin
            bufData_d[15:8] = pwdata[7:0];
          end
        end
        fcf_pkg::IDX_DATA_LO: begin
          if (!bufFull_q) begin
            bufData_d[7:0] = pwdata[7:0];
          end
        end
        default: begin
          // Security and factory-test registers ignore writes.
        end
      endcase
    end
    if (launch) begin
      if (!loaded_q || !cmdWritten_q) begin
        access_error_flag_d = 1'b1;
      end else begin
        bufFull_d    = 1'b1;
        cmdWritten_d = 1'b0;
      end
    end
    if (moveIn) begin
      bufFull_d = 1'b0;
    end
  end

  // Active stage: runs for a fixed count of timing ticks, standing in for the engine.
  always_comb begin
    act_d     = act_q;
    actCmd_d  = actCmd_q;
    actAddr_d = actAddr_q;
    actData_d = actData_q;
    tickCnt_d = tickCnt_q;
    hv_d      = hv_q;
    case (act_q)
      FCF_ACT_IDLE: begin
        tickCnt_d = 8'h00;
      end
      FCF_ACT_RUN: begin
        if (done) begin
          tickCnt_d = 8'h00;
          act_d     = keepHv ? FCF_ACT_RUN : FCF_ACT_IDLE;
          hv_d      = keepHv;
        end else if (flashTimingTick) begin
          tickCnt_d = tickCnt_q + 8'h01;
        end
      end
      default: begin
        act_d = FCF_ACT_IDLE;
      end
    endcase
    if (moveIn) begin
      act_d     = FCF_ACT_RUN;
      actCmd_d  = bufCmd_q;
      actAddr_d = bufAddr_q;
      actData_d = bufData_q;
      hv_d      = 1'b1;
    end
  end

  // Read data is captured in the setup cycle so the access phase answers at once.
  always_comb begin
    rdata_d  = fcf_pkg::READ_ZERO;
    slvErr_d = 1'b0;
    if (setup) begin
      slvErr_d = !mapped;
      if (mapped && !pwrite) begin
        case (idx)
          fcf_pkg::IDX_DIVIDER: rdata_d[7:0] = {loaded_q, prescale_q, divField_q};
          fcf_pkg::IDX_SECURITY: rdata_d[7:0] = security_q;
          fcf_pkg::IDX_CONFIG: begin
            rdata_d[fcf_pkg::CFG_BEMPTY_IE_BIT] = bEmptyIe_q;
            rdata_d[fcf_pkg::CFG_CDONE_IE_BIT]  = cDoneIe_q;
          end
          fcf_pkg::IDX_STATUS: begin
            rdata_d[fcf_pkg::STAT_BEMPTY_BIT] = bufferEmpty;
            rdata_d[fcf_pkg::STAT_CDONE_BIT]  = commandComplete;
            rdata_d[fcf_pkg::STAT_ACCESS_ERROR_FLAG_BIT] = access_error_flag_q;
          end
          fcf_pkg::IDX_COMMAND: rdata_d[6:0] = bufCmd_q;
          fcf_pkg::IDX_ADDR_HI: rdata_d[7:0] = bufAddr_q[15:8];
          fcf_pkg::IDX_ADDR_LO: rdata_d[7:0] = bufAddr_q[7:0];
          fcf_pkg::IDX_DATA_HI: rdata_d[7:0] = bufData_q[15:8];
          fcf_pkg::IDX_DATA_LO: rdata_d[7:0] = bufData_q[7:0];
          default: rdata_d = fcf_pkg::READ_ZERO;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      loaded_q     <= 1'b0;
      prescale_q   <= 1'b0;
      divField_q   <= fcf_pkg::DIV_FIELD_RESET;
      security_q   <= cfgSecurityByte;
      bEmptyIe_q   <= 1'b0;
      cDoneIe_q    <= 1'b0;
      access_error_flag_q     <= 1'b0;
      bufCmd_q     <= fcf_pkg::CMD_RESET;
      bufAddr_q    <= fcf_pkg::WORD_RESET;
      bufData_q    <= fcf_pkg::WORD_RESET;
      cmdWritten_q <= 1'b0;
      bufFull_q    <= 1'b0;
      act_q        <= FCF_ACT_IDLE;
      actCmd_q     <= fcf_pkg::CMD_RESET;
      actAddr_q    <= fcf_pkg::WORD_RESET;
      actData_q    <= fcf_pkg::WORD_RESET;
      tickCnt_q    <= 8'h00;
      hv_q         <= 1'b0;
      rdata_q      <= fcf_pkg::READ_ZERO;
      slvErr_q     <= 1'b0;
    end else begin
      loaded_q     <= loaded_d;
      prescale_q   <= prescale_d;
      divField_q   <= divField_d;
      bEmptyIe_q   <= bEmptyIe_d;
      cDoneIe_q    <= cDoneIe_d;
      access_error_flag_q     <= access_error_flag_d;
      bufCmd_q     <= bufCmd_d;
      bufAddr_q    <= bufAddr_d;
      bufData_q    <= bufData_d;
      cmdWritten_q <= cmdWritten_d;
      bufFull_q    <= bufFull_d;
      act_q        <= act_d;
      actCmd_q     <= actCmd_d;
      actAddr_q    <= actAddr_d;
      actData_q    <= actData_d;
      tickCnt_q    <= tickCnt_d;
      hv_q         <= hv_d;
      rdata_q      <= rdata_d;
      slvErr_q     <= slvErr_d;
    end
  end

  assign prdata             = rdata_q;
  assign pready             = 1'b1;
  assign pslverr            = slvErr_q && psel && penable;
  assign bufferEmptyIrq     = bufferEmpty && bEmptyIe_q;
  assign commandCompleteIrq = commandComplete && cDoneIe_q;
  assign execBusy           = act_q == FCF_ACT_RUN;
  assign execCommand        = actCmd_q;
  assign execAddress        = actAddr_q;
  assign execData           = actData_q;
  assign highVoltageOn      = hv_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_div_write_once: assert property (loaded_q && wrAccess && idx == fcf_pkg::IDX_DIVIDER
    |=> $stable(divField_q) && $stable(prescale_q))
    else $error("divider changed after first write");
  chk_loaded_flag: assert property (wrAccess && idx == fcf_pkg::IDX_DIVIDER
    |=> loaded_q ##1 loaded_q)
    else $error("loaded flag not set after divider write");
  chk_access_error_flag_nodiv: assert property (launch && !loaded_q
    |=> access_error_flag_q && !bufFull_q)
    else $error("command launched without divider");
  chk_queue_accept: assert property (launch && loaded_q && cmdWritten_q
    |=> bufFull_q || execBusy)
    else $error("launched command not queued");
  chk_hv_keep: assert property (done && keepHv
    |=> highVoltageOn && execBusy && execCommand == CMD_WORD_PROGRAM)
    else $error("high voltage dropped between same-row programs");
  chk_hv_drop: assert property (done && !keepHv |=> !highVoltageOn)
    else $error("high voltage held without same-row successor");
  chk_irq_gate: assert property (launch && loaded_q && cmdWritten_q && !execBusy
    |=> ##1 (bufferEmptyIrq == bEmptyIe_q))
    else $error("buffer-empty interrupt not gated by enable");
  chk_reserved_zero: assert property (setup && !pwrite && idx >= fcf_pkg::IDX_TEST_C
    |=> prdata == fcf_pkg::READ_ZERO)
    else $error("factory-test register read nonzero");
  chk_security_ro: assert property (wrAccess && idx == fcf_pkg::IDX_SECURITY
    |=> $stable(security_q))
    else $error("security register changed on write");

  chk_tick_gated: assert property (!loaded_q
    |-> !flashTimingTick)
    else $error("timing tick before divider loaded");
  chk_move_on_idle: assert property (bufFull_q && !execBusy
    |=> execBusy && !bufFull_q)
    else $error("queued command not moved into idle active stage");
  chk_cmd_locked: assert property (bufFull_q && wrAccess && idx == fcf_pkg::IDX_COMMAND
    |=> $stable(bufCmd_q))
    else $error("queued command overwritten while buffer full");
  chk_hv_busy: assert property (execBusy
    |-> highVoltageOn)
    else $error("active stage running without high voltage");
  chk_status_read: assert property (setup && mapped && !pwrite && idx == fcf_pkg::IDX_STATUS
    |=> prdata[fcf_pkg::STAT_BEMPTY_BIT] == !$past(bufFull_q))
    else $error("buffer-empty status bit wrong");
  chk_irq_mask: assert property (!cDoneIe_q
    |-> !commandCompleteIrq)
    else $error("complete interrupt raised while disabled");

  cov_launch_ok: cover property (launch && loaded_q && cmdWritten_q);
  cov_access_error_flag: cover property (launch && !loaded_q);
  cov_hv_chain: cover property (done && keepHv);
  cov_hv_drop: cover property (done && !keepHv);
  cov_div_rewrite: cover property (loaded_q && wrAccess && idx == fcf_pkg::IDX_DIVIDER);
endmodule : fcf_flash_front_end

// *** fcf_pkg.sv ***
// Package with register indices, field positions and reset values of the flash command front end.
// Summary of operation
// - The program and erase engine runs from a timing tick made by dividing the oscillator, not from the bus clock.
// - Command, address and data sit in a two-deep queue of one buffer and one active stage, so a new command is taken while the last one runs.
// - When two word-program commands target the same row and the second is already queued, high voltage stays on between them.
// - A buffer-empty flag and a command-complete flag are raised, and each requests an interrupt only when its enable is set.
// - Divider bit 7 is a read-only loaded flag that reads 0 until the first divider write after reset and 1 afterwards.
// - All divider bits read back; bits 6 to 0 take only the first write after reset and bit 7 ignores every write.
// - Divider bit 6 feeds the oscillator straight into the divider when 0, or divided by eight when 1.
// - The six-bit divide field in bits 5 to 0 with the prescale select sets the ratio, at most 512 overall.
// - The security register reads back in all bits and ignores every write.
// - The security register is loaded from the configuration byte during reset.
// - Each factory-test register reads zero in every bit and ignores writes.
// - A command launched while the divider was never written since reset is not executed and sets the access-error flag.
package fcf_pkg;
  localparam int unsigned REG_COUNT = 16;
  localparam logic [3:0] IDX_DIVIDER   = 4'h0;
  localparam logic [3:0] IDX_SECURITY  = 4'h1;
  localparam logic [3:0] IDX_RSVD_2    = 4'h2;
  localparam logic [3:0] IDX_CONFIG    = 4'h3;
  localparam logic [3:0] IDX_PROTECT   = 4'h4;
  localparam logic [3:0] IDX_STATUS    = 4'h5;
  localparam logic [3:0] IDX_COMMAND   = 4'h6;
  localparam logic [3:0] IDX_RSVD_7    = 4'h7;
  localparam logic [3:0] IDX_ADDR_HI   = 4'h8;
  localparam logic [3:0] IDX_ADDR_LO   = 4'h9;
  localparam logic [3:0] IDX_DATA_HI   = 4'hA;
  localparam logic [3:0] IDX_DATA_LO   = 4'hB;
  localparam logic [3:0] IDX_TEST_C    = 4'hC;
  localparam logic [3:0] IDX_TEST_D    = 4'hD;
  localparam logic [3:0] IDX_TEST_E    = 4'hE;
  localparam logic [3:0] IDX_TEST_F    = 4'hF;
  localparam int unsigned DIV_LOADED_BIT   = 7;
  localparam int unsigned DIV_PRESCALE_BIT = 6;
  localparam int unsigned DIV_FIELD_W      = 6;
  localparam int unsigned CFG_BEMPTY_IE_BIT = 7;
  localparam int unsigned CFG_CDONE_IE_BIT  = 6;
  localparam int unsigned STAT_BEMPTY_BIT   = 7;
  localparam int unsigned STAT_CDONE_BIT    = 6;
  localparam int unsigned STAT_ACCESS_ERROR_FLAG_BIT   = 4;
  localparam int unsigned CMD_W             = 7;
  localparam logic [2:0]  PRESCALE_LAST     = 3'h7;
  localparam logic [5:0]  DIV_FIELD_RESET   = 6'h00;
  localparam logic [6:0]  CMD_RESET         = 7'h00;
  localparam logic [15:0] WORD_RESET        = 16'h0000;
  localparam logic [31:0] READ_ZERO         = 32'h00000000;
endpackage : fcf_pkg

// *** fcf_timing_div.sv ***
// Prescaler and divider that turn oscillator edges into the flash timing tick.
`timescale 1ns/1ns
module fcf_timing_div (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       oscRise,
  input  wire logic       enable,
  input  wire logic       prescaleByEight,
  input  wire logic [5:0] divideField,
  output logic            flashTimingTick
);
  logic [2:0] preCnt_q;
  logic [2:0] preCnt_d;
  logic [5:0] divCnt_q;
  logic [5:0] divCnt_d;
  logic       tick_d;
  logic       stageTick;

  always_comb begin
    preCnt_d = preCnt_q;
    divCnt_d = divCnt_q;
    tick_d   = 1'b0;
    stageTick = 1'b0;
    if (enable && oscRise) begin
      preCnt_d  = preCnt_q + 3'h1;
      stageTick = prescaleByEight ? (preCnt_q == fcf_pkg::PRESCALE_LAST) : 1'b1;
    end
    if (stageTick) begin
      if (divCnt_q == divideField) begin
        divCnt_d = fcf_pkg::DIV_FIELD_RESET;
        tick_d   = 1'b1;
      end else begin
        divCnt_d = divCnt_q + 6'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      preCnt_q        <= 3'h0;
      divCnt_q        <= fcf_pkg::DIV_FIELD_RESET;
      flashTimingTick <= 1'b0;
    end else begin
      preCnt_q        <= preCnt_d;
      divCnt_q        <= divCnt_d;
      flashTimingTick <= tick_d;
    end
  end

  chk_tick_spacing: assert property (@(posedge clk) disable iff (rst)
    flashTimingTick |=> !flashTimingTick)
    else $error("timing tick repeated on consecutive cycles");
endmodule : fcf_timing_div

// *** flash_command_front_end_bench.sv ***
// Self-checking bench of the flash command front end over its APB port.
`timescale 1ns/1ns
`define CHK(got, exp, msg) begin total_checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("Error at %0t: %s", $time, msg); end end
module flash_command_front_end_bench;
  localparam logic [6:0] WP    = 7'h20;
  localparam int         LIMIT = 20000;
  logic        clk = 1'b0;
  logic        oscClk = 1'b0;
  logic        rst, psel, penable, pwrite;
  logic [7:0]  cfgSecurityByte, paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, bufferEmptyIrq, commandCompleteIrq, flashTimingTick;
  logic        execBusy, highVoltageOn;
  logic [6:0]  execCommand;
  logic [15:0] execAddress, execData;
  logic [32:0] notes[$];
  logic [32:0] expNote;
  int          miscompares = 0;
  int          total_checks = 0;
  int          cycles = 0;

  always #2 clk = ~clk;
  // The oscillator is slower than the bus clock and never edges on a bus clock rising edge.
  always #20 oscClk = ~oscClk;

  fcf_flash_front_end #(.CMD_WORD_PROGRAM(WP)) dut_u (
    .clk(clk), .rst(rst), .oscClk(oscClk), .cfgSecurityByte(cfgSecurityByte),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bufferEmptyIrq(bufferEmptyIrq),
    .commandCompleteIrq(commandCompleteIrq), .flashTimingTick(flashTimingTick),
    .execBusy(execBusy), .execCommand(execCommand), .execAddress(execAddress),
    .execData(execData), .highVoltageOn(highVoltageOn));

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  // Reads are noted before the setup cycle and judged where the access completes.
  always @(posedge clk) begin
    cycles++;
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      if (notes.size() == 0) begin
        `CHK(1'b0, 1'b1, "read without a note")
      end else begin
        expNote = notes.pop_front();
        `CHK({pslverr, prdata}, expNote, "read data or error")
      end
    end
    if (cycles > LIMIT) begin
      miscompares++;
      give_verdict();
    end
  end

  // The request stands until pready is seen high; only the bench timeout ends a stuck wait.
  // One idle edge follows each transfer so no strobe is driven twice in one time step.
  task automatic apb(input logic [7:0] a, input logic isWr, input logic [7:0] wd,
                     input logic [32:0] er);
    if (!isWr) begin
      notes.push_back(er);
    end
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= isWr;
    paddr   <= a;
    pwdata  <= {24'h000000, wd};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [3:0] idx, input logic [7:0] v);
    apb({2'b00, idx, 2'b00}, 1'b1, v, '0);
  endtask : wr

  task automatic rd(input logic [3:0] idx, input logic [7:0] v);
    apb({2'b00, idx, 2'b00}, 1'b0, 8'h00, {25'h0000000, v});
  endtask : rd

  task automatic issue(input logic [6:0] c, input logic [15:0] a, input logic [15:0] d);
    wr(fcf_pkg::IDX_COMMAND, {1'b0, c});
    wr(fcf_pkg::IDX_ADDR_HI, a[15:8]);
    wr(fcf_pkg::IDX_ADDR_LO, a[7:0]);
    wr(fcf_pkg::IDX_DATA_HI, d[15:8]);
    wr(fcf_pkg::IDX_DATA_LO, d[7:0]);
    wr(fcf_pkg::IDX_STATUS, 8'h80);
  endtask : issue

  // Counts cycles with high voltage off until the active stage holds the given address.
  task automatic handover(input logic [15:0] a, output int drops);
    int n;
    n = 0;
    drops = 0;
    while (execAddress !== a && n < 3000) begin
      @(posedge clk);
      n++;
      if (highVoltageOn !== 1'b1) drops++;
    end
  endtask : handover

  initial begin
    int          ps, n, gap, drops;
    logic [7:0]  sec;
    logic [5:0]  dv;
    logic [15:0] a1, d1, d2, d3;
    logic [3:0]  tests[5];
    tests = '{fcf_pkg::IDX_RSVD_2, fcf_pkg::IDX_TEST_C, fcf_pkg::IDX_TEST_D,
              fcf_pkg::IDX_TEST_E, fcf_pkg::IDX_TEST_F};
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    cfgSecurityByte = 8'h00;
    void'($urandom(22));
    // The second pass also shows that reset reopens the write-once divider.
    for (ps = 0; ps < 2; ps++) begin
      sec = 8'($urandom());
      dv  = (ps == 1) ? 6'($urandom_range(7, 0)) : 6'($urandom_range(7, 3));
      @(posedge clk);
      rst <= 1'b1;
      cfgSecurityByte <= sec;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(fcf_pkg::IDX_DIVIDER, 8'h00);
      rd(fcf_pkg::IDX_SECURITY, sec);
      wr(fcf_pkg::IDX_SECURITY, ~sec);
      rd(fcf_pkg::IDX_SECURITY, sec);
      rd(fcf_pkg::IDX_STATUS, 8'hC0);
      issue(WP, 16'h0100, 16'h1234);
      rd(fcf_pkg::IDX_STATUS, 8'hD0);
      `CHK(execBusy, 1'b0, "command ran without divider")
      wr(fcf_pkg::IDX_STATUS, 8'h10);
      rd(fcf_pkg::IDX_STATUS, 8'hC0);
      wr(fcf_pkg::IDX_DIVIDER, {1'b0, ps[0], dv});
      rd(fcf_pkg::IDX_DIVIDER, {1'b1, ps[0], dv});
      wr(fcf_pkg::IDX_DIVIDER, 8'hFF);
      wr(fcf_pkg::IDX_DIVIDER, 8'h00);
      rd(fcf_pkg::IDX_DIVIDER, {1'b1, ps[0], dv});
      for (n = 0; n < 5; n++) begin
        wr(tests[n], 8'hFF);
        rd(tests[n], 8'h00);
      end
      apb(8'h40, 1'b1, 8'hFF, '0);
      apb(8'h40, 1'b0, 8'h00, {1'b1, 32'h00000000});
      n = 0;
      while (flashTimingTick !== 1'b1 && n < 2000) begin
        @(posedge clk);
        n++;
      end
      gap = 0;
      do begin
        @(posedge clk);
        gap++;
      end while (flashTimingTick !== 1'b1 && gap < 2000);
      `CHK(gap, (ps == 1 ? 8 : 1) * (int'(dv) + 1) * 10, "tick spacing")
      if (ps == 0) begin
        a1 = {10'($urandom()), 6'h02};
        d1 = 16'($urandom());
        d2 = 16'($urandom());
        d3 = 16'($urandom());
        wr(fcf_pkg::IDX_CONFIG, 8'hC0);
        @(posedge clk);
        `CHK({bufferEmptyIrq, commandCompleteIrq}, 2'b11, "idle interrupts")
        issue(WP, a1, d1);
        n = 0;
        while (execBusy !== 1'b1 && n < 50) begin
          @(posedge clk);
          n++;
        end
        `CHK({execCommand, execAddress, execData}, {WP, a1, d1}, "active stage")
        `CHK(commandCompleteIrq, 1'b0, "complete while busy")
        rd(fcf_pkg::IDX_STATUS, 8'h80);
        issue(WP, a1 + 16'h0002, d2);
        @(posedge clk);
        rd(fcf_pkg::IDX_STATUS, 8'h00);
        `CHK(bufferEmptyIrq, 1'b0, "buffer full interrupt")
        handover(a1 + 16'h0002, drops);
        `CHK(drops, 0, "high voltage dropped in row")
        `CHK(execData, d2, "queued data moved in")
        issue(7'h05, a1 + 16'h0040, d3);
        handover(a1 + 16'h0040, drops);
        `CHK(drops > 0, 1'b1, "high voltage kept across rows")
        n = 0;
        while (execBusy !== 1'b0 && n < 3000) begin
          @(posedge clk);
          n++;
        end
        @(posedge clk);
        `CHK(commandCompleteIrq, 1'b1, "complete interrupt")
        rd(fcf_pkg::IDX_STATUS, 8'hC0);
        wr(fcf_pkg::IDX_CONFIG, 8'h00);
        @(posedge clk);
        `CHK({bufferEmptyIrq, commandCompleteIrq}, 2'b00, "masked interrupts")
      end
      $display("Test pass %0d done", ps);
    end
    repeat (2) @(posedge clk);
    give_verdict();
  end
endmodule : flash_command_front_end_bench
